// >>> rtl/tciu_top.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Notes on behaviour
// - sixteen channels, each with its own service request input into this block.
// - one status flag per channel, set by that channel's time function.
// - one software enable bit per channel gates its flag.
// - request raised when an enabled flag is set and level is non-zero.
// - three-bit level selects line; seven is highest, lower values lower lines.
// - level zero asserts no line at all.
// - contend only when acknowledged level equals the programmed level.
// - arbitrate by driving arbitration number bits serially, one per cycle.
// - arbitration number resets to zero.
// - winner drives vector: base nibble above channel number nibble.
module tciu_top (
	input  wire logic                          ref_clk_i,
	input  wire logic                          nrst_i,
	input  wire tciu_pkg::tciu_bus_req_t       bus_i,
	output logic [tciu_pkg::DATA_W-1:0]        rdata_o,
	input  wire logic [tciu_pkg::NUM_CH-1:0]   flag_set_i,
	output logic [6:0]                         irq_o,
	input  wire tciu_pkg::tciu_iack_t          iack_i,
	input  wire logic                          arb_line_i,
	output logic                               arb_bit_o,
	output logic                               arb_oe_o,
	output logic [7:0]                         vector_o,
	output logic                               vector_oe_o,
	output logic                               evt_irq_o
);
	import tciu_pkg::*;

	logic [ARB_W-1:0]   arb_num_q;
	logic               emu_q;
	logic [CH_W-1:0]    vbase_q;
	logic [LVL_W-1:0]   lvl_q;
	logic [NUM_CH-1:0]  enable_q;
	logic [NUM_CH-1:0]  status_q;
	logic [NUM_EVT-1:0] evt_status_q;
	logic [NUM_EVT-1:0] evt_mask_q;
	logic [NUM_EVT-1:0] evt_set;
	logic [DATA_W-1:0]  rdata_q;
	logic [DATA_W-1:0]  rdata_d;
	logic [6:0]         irq_q;
	logic [6:0]         irq_d;
	logic [NUM_CH-1:0]  pending;
	logic               any_pending;
	logic [CH_W-1:0]    lowest;
	logic [CH_W-1:0]    chan_q;
	logic [7:0]         vector_q;
	logic               vector_oe_q;
	logic               evt_irq_q;
	logic               level_match;
	logic               start_arb;
	logic               arb_busy;
	logic               arb_done;
	logic               arb_won;
	logic               arb_bit;
	tciu_ack_state_t    state_q;

	logic wr_cfg;
	logic wr_icfg;
	logic wr_en;
	logic wr_st;
	logic wr_est;
	logic wr_emask;

	assign wr_cfg   = bus_i.wr && (bus_i.addr == OFS_MODULE_CFG);
	assign wr_icfg  = bus_i.wr && (bus_i.addr == OFS_IRQ_CFG);
	assign wr_en    = bus_i.wr && (bus_i.addr == OFS_CH_ENABLE);
	assign wr_st    = bus_i.wr && (bus_i.addr == OFS_CH_STATUS);
	assign wr_est   = bus_i.wr && (bus_i.addr == OFS_EVT_STATUS);
	assign wr_emask = bus_i.wr && (bus_i.addr == OFS_EVT_MASK);

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			arb_num_q <= ARB_RST;
			emu_q     <= 1'b0;
		end else if (wr_cfg) begin
			arb_num_q <= bus_i.wdata[ARB_LSB +: ARB_W];
			emu_q     <= bus_i.wdata[EMU_BIT];
		end
	end

	// vector base resets to zero; software must load it before enabling channels
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			vbase_q <= VBASE_RST;
			lvl_q   <= LVL_RST;
		end else if (wr_icfg) begin
			vbase_q <= bus_i.wdata[VBASE_LSB +: CH_W];
			lvl_q   <= bus_i.wdata[LVL_LSB +: LVL_W];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			enable_q <= CH_RST;
		end else if (wr_en) begin
			enable_q <= bus_i.wdata[NUM_CH-1:0];
		end
	end

	// per channel flag: write one clears, a set in the same cycle wins
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			always_ff @(posedge ref_clk_i) begin
				if (!nrst_i) begin
					status_q[g] <= 1'b0;
				end else if (flag_set_i[g]) begin
					status_q[g] <= 1'b1;
				end else if (wr_st && bus_i.wdata[g]) begin
					status_q[g] <= 1'b0;
				end
			end
			assign pending[g] = status_q[g] && enable_q[g];
		end
	endgenerate

	assign any_pending = |pending;

	always_comb begin
		lowest = 4'h0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (pending[i]) begin
				lowest = i[CH_W-1:0];
			end
		end
	end

	// one line per level; line index is level minus one
	always_comb begin
		irq_d = 7'h00;
		if (any_pending && (lvl_q != 3'h0)) begin
			irq_d[lvl_q - 3'h1] = 1'b1;
		end
	end

	// request stays up after an acknowledge while any enabled flag pends
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			irq_q <= 7'h00;
		end else begin
			irq_q <= irq_d;
		end
	end

	// host only acknowledges levels above its mask, so level match is enough
	assign level_match = iack_i.valid && (iack_i.level == lvl_q) && (lvl_q != 3'h0);
	// a zero arbitration number loses to any nonzero rival, so it does not contend
	assign start_arb   = (state_q == ACK_IDLE) && level_match && any_pending
	                   && (arb_num_q != 4'h0);

	tciu_serial_arb u_arb (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.start_i   (start_arb),
		.arb_num_i (arb_num_q),
		.line_i    (arb_line_i),
		.bit_o     (arb_bit),
		.busy_o    (arb_busy),
		.done_o    (arb_done),
		.won_o     (arb_won)
	);

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_q <= ACK_IDLE;
			chan_q  <= 4'h0;
		end else begin
			case (state_q)
				ACK_IDLE: begin
					if (start_arb) begin
						chan_q  <= lowest;
						state_q <= ACK_ARB;
					end
				end
				ACK_ARB: begin
					if (arb_done) begin
						state_q <= arb_won ? ACK_VECTOR : ACK_IDLE;
					end
				end
				ACK_VECTOR: begin
					state_q <= ACK_IDLE;
				end
				default: begin
					state_q <= ACK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			vector_q    <= 8'h00;
			vector_oe_q <= 1'b0;
		end else if ((state_q == ACK_ARB) && arb_done && arb_won) begin
			vector_q    <= {vbase_q, chan_q};
			vector_oe_q <= 1'b1;
		end else begin
			vector_q    <= 8'h00;
			vector_oe_q <= 1'b0;
		end
	end

	assign evt_set[EVT_WON]      = (state_q == ACK_ARB) && arb_done && arb_won;
	assign evt_set[EVT_LOST]     = (state_q == ACK_ARB) && arb_done && !arb_won;
	assign evt_set[EVT_SPURIOUS] = (state_q == ACK_IDLE) && level_match && !any_pending;

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			evt_status_q <= EVT_RST;
		end else begin
			evt_status_q <= evt_set | (evt_status_q & ~({NUM_EVT{wr_est}} & bus_i.wdata[NUM_EVT-1:0]));
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			evt_mask_q <= EVT_RST;
		end else if (wr_emask) begin
			evt_mask_q <= bus_i.wdata[NUM_EVT-1:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			evt_irq_q <= 1'b0;
		end else begin
			evt_irq_q <= |(evt_status_q & evt_mask_q);
		end
	end

	always_comb begin
		rdata_d = '0;
		if (bus_i.addr == OFS_MODULE_CFG) begin
			rdata_d[ARB_LSB +: ARB_W] = arb_num_q;
			rdata_d[EMU_BIT]          = emu_q;
		end else if (bus_i.addr == OFS_IRQ_CFG) begin
			rdata_d[VBASE_LSB +: CH_W] = vbase_q;
			rdata_d[LVL_LSB +: LVL_W]  = lvl_q;
		end else if (bus_i.addr == OFS_CH_ENABLE) begin
			rdata_d[NUM_CH-1:0] = enable_q;
		end else if (bus_i.addr == OFS_CH_STATUS) begin
			rdata_d[NUM_CH-1:0] = status_q;
		end else if (bus_i.addr == OFS_EVT_STATUS) begin
			rdata_d[NUM_EVT-1:0] = evt_status_q;
		end else if (bus_i.addr == OFS_EVT_MASK) begin
			rdata_d[NUM_EVT-1:0] = evt_mask_q;
		end
	end

	// read data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= bus_i.rd ? rdata_d : '0;
		end
	end

	assign rdata_o     = rdata_q;
	assign irq_o       = irq_q;
	assign arb_bit_o   = arb_bit;
	assign arb_oe_o    = arb_busy;
	assign vector_o    = vector_q;
	assign vector_oe_o = vector_oe_q;
	assign evt_irq_o   = evt_irq_q;

	property p_irq_zero_level;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(lvl_q == 3'h0) |=> (irq_o == 7'h00);
	endproperty
	a_irq_zero_level: assert property (p_irq_zero_level) else $error("line asserted at level zero");

	property p_irq_onehot;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(any_pending && lvl_q != 3'h0) |=> (irq_o == (7'h01 << ($past(lvl_q) - 3'h1)));
	endproperty
	a_irq_onehot: assert property (p_irq_onehot) else $error("wrong request line");

	property p_irq_needs_pending;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		!any_pending |=> (irq_o == 7'h00);
	endproperty
	a_irq_needs_pending: assert property (p_irq_needs_pending) else $error("request without enabled flag");

	property p_flag_sets;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(flag_set_i != 16'h0000) |=> ((status_q & $past(flag_set_i)) == $past(flag_set_i));
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("flag set lost");

	property p_enable_gates;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(enable_q == 16'h0000) |=> (irq_o == 7'h00);
	endproperty
	a_enable_gates: assert property (p_enable_gates) else $error("disabled flag pending");

	property p_contend_match;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		start_arb |-> (iack_i.level == lvl_q && arb_num_q != 4'h0);
	endproperty
	a_contend_match: assert property (p_contend_match) else $error("contended on wrong level");

	property p_arb_bounded;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		start_arb |=> arb_oe_o ##[1:4] arb_done;
	endproperty
	a_arb_bounded: assert property (p_arb_bounded) else $error("arbitration not serial in four bits");

	property p_arb_msb_first;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		start_arb |=> (arb_bit_o == $past(arb_num_q[3]));
	endproperty
	a_arb_msb_first: assert property (p_arb_msb_first) else $error("first arbitration bit wrong");

	property p_arb_reset;
		@(posedge ref_clk_i)
		!nrst_i |=> (arb_num_q == 4'h0);
	endproperty
	a_arb_reset: assert property (p_arb_reset) else $error("arbitration number not cleared");

	property p_vector_value;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		vector_oe_o |-> (vector_o == {$past(vbase_q), chan_q});
	endproperty
	a_vector_value: assert property (p_vector_value) else $error("bad vector");

	property p_lowest_chan;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		start_arb |=> (chan_q == $past(lowest));
	endproperty
	a_lowest_chan: assert property (p_lowest_chan) else $error("not lowest channel");

	property p_vector_after_win;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(state_q == ACK_ARB && arb_done && arb_won) |=> vector_oe_o ##1 !vector_oe_o;
	endproperty
	a_vector_after_win: assert property (p_vector_after_win) else $error("vector not one cycle");

	c_win: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) evt_set[EVT_WON]);
	c_lose: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) evt_set[EVT_LOST]);
	c_spurious: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) evt_set[EVT_SPURIOUS]);
	c_level7: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) irq_o[6]);

endmodule : tciu_top

// >>> include/tciu_pkg.sv
package tciu_pkg;

	localparam int unsigned NUM_CH     = 16;
	localparam int unsigned CH_W       = 4;
	localparam int unsigned LVL_W      = 3;
	localparam int unsigned ARB_W      = 4;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned NUM_EVT    = 3;

	// register byte offsets
	localparam logic [7:0] OFS_MODULE_CFG = 8'h00;
	localparam logic [7:0] OFS_IRQ_CFG    = 8'h04;
	localparam logic [7:0] OFS_CH_ENABLE  = 8'h08;
	localparam logic [7:0] OFS_CH_STATUS  = 8'h0c;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
	localparam logic [7:0] OFS_EVT_MASK   = 8'h14;

	// field positions
	localparam int unsigned ARB_LSB   = 0;
	localparam int unsigned EMU_BIT   = 15;
	localparam int unsigned VBASE_LSB = 4;
	localparam int unsigned LVL_LSB   = 8;

	// event bit positions
	localparam int unsigned EVT_WON      = 0;
	localparam int unsigned EVT_LOST     = 1;
	localparam int unsigned EVT_SPURIOUS = 2;

	// reset values
	localparam logic [ARB_W-1:0]   ARB_RST   = 4'h0;
	localparam logic [CH_W-1:0]    VBASE_RST = 4'h0;
	localparam logic [LVL_W-1:0]   LVL_RST   = 3'h0;
	localparam logic [NUM_CH-1:0]  CH_RST    = 16'h0000;
	localparam logic [NUM_EVT-1:0] EVT_RST   = 3'h0;

	// serial arbitration: one bus cycle per arbitration bit, msb first
	localparam logic [1:0] ARB_FIRST_IDX = 2'h3;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} tciu_bus_req_t;

	typedef struct packed {
		logic             valid;
		logic [LVL_W-1:0] level;
	} tciu_iack_t;

	typedef enum logic [1:0] {
		ACK_IDLE,
		ACK_ARB,
		ACK_VECTOR
	} tciu_ack_state_t;

endpackage : tciu_pkg

// >>> rtl/tciu_serial_arb.sv
`timescale 1ns/100ps
module tciu_serial_arb (
	input  wire logic                       ref_clk_i,
	input  wire logic                       nrst_i,
	input  wire logic                       start_i,
	input  wire logic [tciu_pkg::ARB_W-1:0] arb_num_i,
	input  wire logic                       line_i,
	output logic                            bit_o,
	output logic                            busy_o,
	output logic                            done_o,
	output logic                            won_o
);
	import tciu_pkg::*;

	logic [ARB_W-1:0] num_q;
	logic [1:0]       idx_q;
	logic             bit_q;
	logic             busy_q;
	logic             done_q;
	logic             won_q;

	// number is frozen at start so a register write cannot corrupt a contest
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			num_q  <= ARB_RST;
			idx_q  <= 2'h0;
			bit_q  <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			won_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start_i) begin
				num_q  <= arb_num_i;
				idx_q  <= ARB_FIRST_IDX;
				bit_q  <= arb_num_i[ARB_FIRST_IDX];
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (!bit_q && line_i) begin
					busy_q <= 1'b0;
					bit_q  <= 1'b0;
					done_q <= 1'b1;
					won_q  <= 1'b0;
				end else if (idx_q == 2'h0) begin
					busy_q <= 1'b0;
					bit_q  <= 1'b0;
					done_q <= 1'b1;
					won_q  <= 1'b1;
				end else begin
					idx_q <= idx_q - 2'h1;
					bit_q <= num_q[idx_q - 2'h1];
				end
			end
		end
	end

	assign bit_o  = bit_q;
	assign busy_o = busy_q;
	assign done_o = done_q;
	assign won_o  = won_q;

endmodule : tciu_serial_arb

// >>> dv/tciu_host_model.sv
`timescale 1ns/100ps
module tciu_host_model (
	input  wire logic            ref_clk_i,
	input  wire logic            nrst_i,
	input  wire logic [6:0]      irq_i,
	input  wire logic [2:0]      mask_i,
	input  wire logic            go_i,
	input  wire logic [2:0]      force_lvl_i,
	input  wire logic [3:0]      rival_num_i,
	input  wire logic            arb_bit_i,
	input  wire logic            arb_oe_i,
	output tciu_pkg::tciu_iack_t iack_o,
	output logic                 line_o
);
	import tciu_pkg::*;
	logic [2:0] top_lvl;
	logic       ract_q;
	logic [1:0] ridx_q;
	always_comb begin
		top_lvl = 3'h0;
		for (int i = 0; i < 7; i++) begin
			if (irq_i[i]) top_lvl = 3'(i + 1);
		end
	end
	// a forced level is an acknowledge the bench provokes on purpose
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) iack_o <= '0;
		else if (go_i && force_lvl_i != 3'h0) iack_o <= '{valid: 1'b1, level: force_lvl_i};
		else if (go_i && top_lvl > mask_i) iack_o <= '{valid: 1'b1, level: top_lvl};
		else iack_o <= '0;
	end
	// rival module at the same level; drops out once it sees a one over its zero
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			ract_q <= 1'b0;
			ridx_q <= 2'h3;
		end else if (iack_o.valid) begin
			ract_q <= rival_num_i != 4'h0;
			ridx_q <= 2'h3;
		end else if (ract_q) begin
			if (ridx_q == 2'h0 || (!rival_num_i[ridx_q] && line_o)) ract_q <= 1'b0;
			ridx_q <= ridx_q - 2'h1;
		end
	end
	// wired-or line, pulled low when nobody drives
	assign line_o = (arb_oe_i & arb_bit_i) | (ract_q & rival_num_i[ridx_q]);
endmodule : tciu_host_model

// >>> dv/tciu_top_tb_top.sv
`timescale 1ns/100ps
module tciu_top_tb_top;
	import tciu_pkg::*;
	typedef struct packed {
		logic [2:0] lvl;
		logic       en;
		logic [3:0] ch;
		logic [6:0] irq;
	} tciu_row_t;
	logic          ref_clk_i, nrst_i, go_q, line, abit, aoe, voe, eirq, oe, a;
	tciu_bus_req_t bus_q;
	tciu_iack_t    iack;
	logic [31:0]   rdata;
	logic [15:0]   flag_q;
	logic [6:0]    irq;
	logic [7:0]    vec, v;
	logic [2:0]    mask_q, frc_q;
	logic [3:0]    rival_q, bits;
	int            fail_count = 0;
	int            tests_run = 0;
	logic [7:0]    regs [7] = '{OFS_MODULE_CFG, OFS_IRQ_CFG, OFS_CH_ENABLE, OFS_CH_STATUS,
		OFS_EVT_STATUS, OFS_EVT_MASK, 8'h18};
	tciu_row_t     rows [9] = '{'{3'h7, 1'b1, 4'hf, 7'h40}, '{3'h1, 1'b1, 4'h0, 7'h01},
		'{3'h5, 1'b1, 4'h3, 7'h10}, '{3'h2, 1'b1, 4'h8, 7'h02}, '{3'h3, 1'b1, 4'h1, 7'h04},
		'{3'h4, 1'b1, 4'h6, 7'h08}, '{3'h6, 1'b1, 4'hc, 7'h20}, '{3'h0, 1'b1, 4'h2, 7'h00},
		'{3'h4, 1'b0, 4'h5, 7'h00}};

	tciu_top tciu_top_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_i(bus_q), .rdata_o(rdata),
		.flag_set_i(flag_q), .irq_o(irq), .iack_i(iack), .arb_line_i(line), .arb_bit_o(abit),
		.arb_oe_o(aoe), .vector_o(vec), .vector_oe_o(voe), .evt_irq_o(eirq));
	tciu_host_model tciu_host_model_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .irq_i(irq),
		.mask_i(mask_q), .go_i(go_q), .force_lvl_i(frc_q), .rival_num_i(rival_q), .arb_bit_i(abit),
		.arb_oe_i(aoe), .iack_o(iack), .line_o(line));

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	task automatic complete_run();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge ref_clk_i);
		bus_q <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_i);
		bus_q <= '0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string n);
		@(posedge ref_clk_i);
		bus_q <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_i);
		bus_q <= '0;
		#1;
		chk(n, rdata, e);
		@(posedge ref_clk_i);
		#1;
		chk({n, " gone"}, rdata, 0);
	endtask : rd

	task automatic pulse_flag(input logic [15:0] m);
		@(posedge ref_clk_i);
		flag_q <= m;
		@(posedge ref_clk_i);
		flag_q <= '0;
	endtask : pulse_flag

	// one acknowledge; the whole contest fits well inside the fixed window
	task automatic ack(input logic [2:0] f, input logic [3:0] rv);
		bits = '0;
		oe = 1'b0;
		v = '0;
		@(posedge ref_clk_i);
		go_q <= 1'b1;
		frc_q <= f;
		rival_q <= rv;
		@(posedge ref_clk_i);
		go_q <= 1'b0;
		repeat (14) begin
			cyc(1);
			if (aoe) begin
				bits = {bits[2:0], abit};
				oe = 1'b1;
			end
			if (voe) v = vec;
			else chk("vector idle", vec, 0);
		end
	endtask : ack

	initial begin
		repeat (100000) @(posedge ref_clk_i);
		fail_count++;
		complete_run();
	end

	initial begin
		nrst_i = 1'b0;
		bus_q = '0;
		flag_q = '0;
		go_q = 1'b0;
		mask_q = 3'h0;
		frc_q = 3'h0;
		rival_q = 4'h0;
		repeat (20) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		foreach (rows[i]) begin
			wr(OFS_IRQ_CFG, (32'(rows[i].lvl) << 8) | 32'h0000_00a0);
			wr(OFS_CH_ENABLE, 32'(rows[i].en) << rows[i].ch);
			pulse_flag(16'h1 << rows[i].ch);
			cyc(2);
			chk("irq lines", irq, rows[i].irq);
			rd(OFS_CH_STATUS, 32'h1 << rows[i].ch, "channel status");
			wr(OFS_CH_STATUS, 32'h1 << rows[i].ch);
			cyc(2);
			chk("irq after clear", irq, 0);
		end
		wr(OFS_IRQ_CFG, 32'h0000_03a0);
		wr(OFS_CH_ENABLE, 32'h0000_0210);
		pulse_flag(16'h0210);
		ack(3'h0, 4'h0);
		chk("zero number contends", oe, 0);
		wr(OFS_MODULE_CFG, 32'h0000_8005);
		wr(OFS_IRQ_CFG, 32'h0000_03a0);
		rd(OFS_MODULE_CFG, 32'h0000_8005, "module cfg");
		rd(OFS_IRQ_CFG, 32'h0000_03a0, "irq cfg");
		ack(3'h0, 4'h0);
		chk("arb bits", bits, 4'h5);
		chk("vector", v, 8'ha4);
		chk("irq after ack", irq, 7'h04);
		rd(OFS_EVT_STATUS, 32'h1, "won event");
		wr(OFS_EVT_STATUS, 32'h7);
		ack(3'h2, 4'h0);
		chk("other level contends", oe, 0);
		ack(3'h0, 4'h7);
		chk("lost bits", bits, 4'h2);
		chk("lost vector", v, 0);
		rd(OFS_EVT_STATUS, 32'h2, "lost event");
		wr(OFS_EVT_STATUS, 32'h7);
		wr(OFS_CH_STATUS, 32'h0000_0210);
		ack(3'h3, 4'h0);
		chk("spurious contends", oe, 0);
		rd(OFS_EVT_STATUS, 32'h4, "spurious event");
		wr(OFS_EVT_MASK, 32'h7);
		cyc(2);
		a = eirq;
		rd(OFS_EVT_MASK, 32'h7, "event mask");
		wr(OFS_EVT_MASK, 32'h0);
		cyc(2);
		chk("event irq set", a, 1);
		chk("event irq masked", eirq, 0);
		wr(OFS_EVT_STATUS, 32'h4);
		cyc(2);
		chk("event irq cleared", eirq, 0);
		wr(OFS_EVT_MASK, 32'h7);
		cyc(2);
		chk("event irq cleared", eirq, 0);
		// leave a request standing so the reset has something to clear
		pulse_flag(16'h0010);
		cyc(2);
		chk("irq before reset", irq, 7'h04);
		@(posedge ref_clk_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		foreach (regs[i]) rd(regs[i], 0, "reset value");
		chk("irq after reset", irq, 0);
		complete_run();
	end
endmodule : tciu_top_tb_top
